//--- rtl/lvds_bidir_serdes_lane.sv
// Bidirectional serdes lane: serializer, deserializer, FIFO, alignment
`timescale 1ns/1ps
module lvds_bidir_serdes_lane (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdData,
	input wire logic rx_word_clock,
	input wire logic rx_bit_clock,
	input wire logic tx_word_clock,
	input wire logic tx_bit_clock,
	input wire logic core_read_clock,
	input wire logic rx_path_reset,
	input wire logic tx_path_reset,
	input wire logic input_buffer_on,
	input wire logic line_resistor_on,
	input wire logic delay_step_go,
	input wire logic delay_step_up,
	input wire logic delay_counter_clear,
	input wire logic rx_queue_pop,
	input wire logic pad_drive_on,
	input wire logic [9:0] txWord,
	input wire logic padIn,
	output logic [9:0] rxWord,
	output logic align_achieved,
	output logic rx_queue_empty,
	output logic [5:0] align_tap_report,
	output logic [5:0] delayTap,
	output logic padPOut,
	output logic padNOut,
	output logic padOeN,
	output logic inputBufferEnable,
	output logic termConnect
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [9:0] widthMask(input logic [3:0] w);
		widthMask = ~(lane_pkg::FULL_MASK << w);
	endfunction : widthMask

	function automatic logic [9:0] alignDown(input logic [9:0] s,
		input logic [3:0] w);
		alignDown = s >> (lane_pkg::WIDTH_MAX - w);
	endfunction : alignDown

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	lane_pkg::pins_s pinsA;
	lane_pkg::pins_s pinsB;
	lane_pkg::pins_s pinsC;
	logic [9:0] txWordA;
	logic [9:0] txWordB;
	// Word is stable around its clock edge, so bitwise sync is safe
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pinsA <= '0;
			pinsB <= '0;
			pinsC <= '0;
			txWordA <= '0;
			txWordB <= '0;
		end else begin
			pinsA <= '{rx_word_clock, rx_bit_clock, tx_word_clock,
				tx_bit_clock, core_read_clock, tx_path_reset,
				input_buffer_on, line_resistor_on, delay_step_go,
				delay_step_up, delay_counter_clear, rx_queue_pop,
				pad_drive_on, padIn};
			pinsB <= pinsA;
			pinsC <= pinsB;
			txWordA <= txWord;
			txWordB <= txWordA;
		end
	end

	lane_pkg::ctrl_s ctrlReg;
	logic [9:0] patternReg;
	logic rxWordEdge;
	logic txWordEdge;
	logic rdEdge;
	logic rxBitEdge;
	logic txBitEdge;
	logic alignOn;
	logic rxRstN;
	assign rxWordEdge = pinsB.rxWordClk & ~pinsC.rxWordClk;
	assign txWordEdge = pinsB.txWordClk & ~pinsC.txWordClk;
	assign rdEdge = pinsB.coreRdClk & ~pinsC.coreRdClk;
	assign rxBitEdge = ctrlReg.halfRate ? (pinsB.rxBitClk ^ pinsC.rxBitClk)
		: (pinsB.rxBitClk & ~pinsC.rxBitClk);
	assign txBitEdge = ctrlReg.halfRate ? (pinsB.txBitClk ^ pinsC.txBitClk)
		: (pinsB.txBitClk & ~pinsC.txBitClk);
	assign alignOn = ctrlReg.autoAlign & ~ctrlReg.halfRate;
	assign rxRstN = arst_n & ~rx_path_reset;

	// ----------------------------------------------------------------
	// Register port
	// ----------------------------------------------------------------
	logic [3:0] fifoCnt;
	lane_pkg::align_e alignState;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrlReg <= lane_pkg::CTRL_RESET;
			patternReg <= lane_pkg::PATTERN_RESET;
		end else if (regWr) begin
			if (regAddr == lane_pkg::CTRL_ADDR) begin
				ctrlReg.staticTerm <= regWrData[8];
				ctrlReg.dynTerm <= regWrData[7];
				ctrlReg.fifoEn <= regWrData[6];
				ctrlReg.autoAlign <= regWrData[5];
				ctrlReg.halfRate <= regWrData[4];
				if (regWrData[3:0] >= lane_pkg::WIDTH_MIN &&
					regWrData[3:0] <= lane_pkg::WIDTH_MAX) begin
					ctrlReg.width <= regWrData[3:0];
				end
			end
			if (regAddr == lane_pkg::PATTERN_ADDR) begin
				patternReg <= regWrData[9:0];
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			regRdData <= '0;
		end else if (regRd) begin
			case (regAddr)
				lane_pkg::CTRL_ADDR: begin
					regRdData <= {23'h0, ctrlReg};
				end
				lane_pkg::PATTERN_ADDR: begin
					regRdData <= {22'h0, patternReg};
				end
				lane_pkg::STATUS_ADDR: begin
					regRdData <= {20'h0, fifoCnt, delayTap,
						rx_queue_empty, align_achieved};
				end
				default: begin
					regRdData <= '0;
				end
			endcase
		end else begin
			regRdData <= '0;
		end
	end

	// ----------------------------------------------------------------
	// Pad controls
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			inputBufferEnable <= 1'b0;
			termConnect <= 1'b0;
			padOeN <= 1'b1;
		end else begin
			inputBufferEnable <= pinsB.bufOn;
			termConnect <= ctrlReg.dynTerm ? pinsB.termOn
				: ctrlReg.staticTerm;
			padOeN <= ~pinsB.driveOn;
		end
	end

	// ----------------------------------------------------------------
	// Serializer
	// ----------------------------------------------------------------
	logic [9:0] txShift;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			txShift <= '0;
			padPOut <= 1'b0;
			padNOut <= 1'b1;
		end else if (pinsB.txRst) begin
			txShift <= '0;
			padPOut <= 1'b0;
			padNOut <= 1'b1;
		end else begin
			if (txWordEdge) begin
				txShift <= txWordB & widthMask(ctrlReg.width);
			end else if (txBitEdge) begin
				txShift <= {1'b0, txShift[9:1]};
			end
			if (txBitEdge) begin
				padPOut <= txShift[0];
				padNOut <= ~txShift[0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Deserializer
	// ----------------------------------------------------------------
	logic [9:0] rxShift;
	logic [9:0] deserOut;
	logic rxBit;
	assign rxBit = pinsB.padIn & inputBufferEnable;
	// low bits hold the configured width
	assign deserOut = alignDown(rxShift, ctrlReg.width);
	always_ff @(posedge clk or negedge rxRstN) begin
		if (!rxRstN) begin
			rxShift <= '0;
		end else if (rxBitEdge) begin
			rxShift <= {rxBit, rxShift[9:1]};
		end
	end

	// ----------------------------------------------------------------
	// Delay control and alignment
	// ----------------------------------------------------------------
	logic [3:0] runCnt;
	logic wordMatch;
	assign wordMatch = deserOut == (patternReg & widthMask(ctrlReg.width));
	always_ff @(posedge clk or negedge rxRstN) begin
		if (!rxRstN) begin
			delayTap <= '0;
			runCnt <= '0;
			alignState <= lane_pkg::AL_IDLE;
			align_achieved <= 1'b0;
			align_tap_report <= '0;
		end else if (rxWordEdge) begin
			if (pinsB.cntClr) begin
				delayTap <= '0;
				runCnt <= '0;
				alignState <= lane_pkg::AL_IDLE;
				align_achieved <= 1'b0;
			end else if (!alignOn) begin
				if (pinsB.stepGo) begin
					if (pinsB.stepUp && delayTap != lane_pkg::TAP_TOP) begin
						delayTap <= delayTap + 6'h01;
					end else if (!pinsB.stepUp && delayTap != 6'h00) begin
						delayTap <= delayTap - 6'h01;
					end
				end
			end else begin
				case (alignState)
					lane_pkg::AL_IDLE: begin
						if (pinsB.stepGo) begin
							alignState <= lane_pkg::AL_SCAN;
						end
					end
					lane_pkg::AL_SCAN: begin
						// Centre of a run of passing taps
						if (wordMatch && runCnt == lane_pkg::ALIGN_RUN - 4'h1)
							begin
							delayTap <= delayTap - lane_pkg::ALIGN_BACK;
							align_tap_report <= delayTap
								- lane_pkg::ALIGN_BACK;
							align_achieved <= 1'b1;
							alignState <= lane_pkg::AL_LOCK;
						end else begin
							runCnt <= wordMatch ? runCnt + 4'h1 : 4'h0;
							delayTap <= delayTap + 6'h01;
						end
					end
					lane_pkg::AL_LOCK: begin
						align_achieved <= 1'b1;
					end
					default: begin
						alignState <= lane_pkg::AL_IDLE;
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Receive FIFO and parallel output
	// ----------------------------------------------------------------
	logic [9:0] fifoMem [lane_pkg::FIFO_DEPTH];
	logic [2:0] wrPtr;
	logic [2:0] rdPtr;
	logic doWrite;
	logic doPop;
	logic [3:0] fifoCntNext;
	// Words arriving while full are dropped; reader must keep up
	assign doWrite = ctrlReg.fifoEn & rxWordEdge &
		(fifoCnt != 4'(lane_pkg::FIFO_DEPTH));
	assign doPop = ctrlReg.fifoEn & rdEdge & pinsB.qPop & (fifoCnt != 4'h0);
	assign fifoCntNext = fifoCnt + {3'h0, doWrite} - {3'h0, doPop};

	always_ff @(posedge clk or negedge rxRstN) begin
		if (!rxRstN) begin
			for (int i = 0; i < lane_pkg::FIFO_DEPTH; i++) begin
				fifoMem[i] <= '0;
			end
			wrPtr <= '0;
			rdPtr <= '0;
			fifoCnt <= '0;
			rx_queue_empty <= 1'b1;
			rxWord <= '0;
		end else begin
			if (doWrite) begin
				fifoMem[wrPtr] <= deserOut;
				wrPtr <= wrPtr + 3'h1;
			end
			if (doPop) begin
				rxWord <= fifoMem[rdPtr];
				rdPtr <= rdPtr + 3'h1;
			end else if (!ctrlReg.fifoEn && rxWordEdge) begin
				rxWord <= deserOut;
			end
			fifoCnt <= fifoCntNext;
			rx_queue_empty <= fifoCntNext == 4'h0;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rxRstN);

	property p_txLoad;
		txWordEdge && !pinsB.txRst |=>
			txShift == ($past(txWordB) & widthMask(ctrlReg.width));
	endproperty
	a_txLoad: assert property (p_txLoad)
		else $error("transmit word not captured");

	property p_rxOut;
		!ctrlReg.fifoEn && rxWordEdge |=> rxWord == $past(deserOut);
	endproperty
	a_rxOut: assert property (p_rxOut)
		else $error("received word not presented");

	property p_lock;
		$rose(align_achieved) |->
			alignState == lane_pkg::AL_LOCK && align_tap_report == delayTap;
	endproperty
	a_lock: assert property (p_lock)
		else $error("lock without chosen tap");

	property p_empty;
		rx_queue_empty == (fifoCnt == 4'h0);
	endproperty
	a_empty: assert property (p_empty)
		else $error("empty flag disagrees with fill");

	sequence s_popReq;
		rdEdge && pinsB.qPop;
	endsequence
	property p_popOnly;
		!$stable(rdPtr) |-> $past(rdEdge && pinsB.qPop);
	endproperty
	a_popOnly: assert property (p_popOnly)
		else $error("read side moved without pop");

	property p_popMoves;
		s_popReq ##0 fifoCnt != 4'h0 && ctrlReg.fifoEn |=>
			rdPtr == $past(rdPtr) + 3'h1;
	endproperty
	a_popMoves: assert property (p_popMoves)
		else $error("pop did not advance read side");

	property p_rxRst;
		disable iff (!arst_n)
		rx_path_reset |-> fifoCnt == 4'h0 && rxShift == 10'h0;
	endproperty
	a_rxRst: assert property (p_rxRst)
		else $error("receive path not cleared");

	property p_stepUp;
		rxWordEdge && !alignOn && pinsB.stepGo && pinsB.stepUp &&
			!pinsB.cntClr && delayTap != lane_pkg::TAP_TOP |=>
			delayTap == $past(delayTap) + 6'h01;
	endproperty
	a_stepUp: assert property (p_stepUp)
		else $error("tap did not increment");

	property p_clear;
		rxWordEdge && pinsB.cntClr |=> delayTap == 6'h00 && !align_achieved;
	endproperty
	a_clear: assert property (p_clear)
		else $error("delay clear ignored");

	property p_txRst;
		disable iff (!arst_n)
		pinsB.txRst |=> txShift == 10'h0 && !padPOut && padNOut;
	endproperty
	a_txRst: assert property (p_txRst)
		else $error("serializer not cleared");

	property p_drive;
		disable iff (!arst_n)
		padOeN == !$past(pinsB.driveOn);
	endproperty
	a_drive: assert property (p_drive)
		else $error("pad enable does not follow drive");

	property p_halfNoAlign;
		ctrlReg.halfRate && $past(ctrlReg.halfRate) && rxWordEdge &&
			!pinsB.cntClr |=> $stable(alignState);
	endproperty
	a_halfNoAlign: assert property (p_halfNoAlign)
		else $error("aligner moved at half rate");

endmodule : lvds_bidir_serdes_lane

//--- inc/lane_pkg.sv
// Constants, field layouts and types for the bidirectional serdes lane
package lane_pkg;

	// ----------------------------------------------------------------
	// Widths and depths
	// ----------------------------------------------------------------
	localparam int DATA_W = 10;
	localparam int TAP_W = 6;
	localparam int FIFO_DEPTH = 8;
	localparam int ADDR_W = 8;
	localparam int BUS_W = 32;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] CTRL_ADDR = 8'h00;
	localparam logic [7:0] PATTERN_ADDR = 8'h04;
	localparam logic [7:0] STATUS_ADDR = 8'h08;
	localparam int STAT_LOCK_BIT = 0;
	localparam int STAT_EMPTY_BIT = 1;
	localparam int STAT_TAP_LSB = 2;
	localparam int STAT_CNT_LSB = 8;

	// ----------------------------------------------------------------
	// Reset values and limits
	// ----------------------------------------------------------------
	localparam logic [3:0] WIDTH_RESET = 4'h8;
	localparam logic [3:0] WIDTH_MIN = 4'h1;
	localparam logic [3:0] WIDTH_MAX = 4'ha;
	localparam logic [9:0] PATTERN_RESET = 10'h155;
	localparam logic [9:0] FULL_MASK = 10'h3ff;
	localparam logic [5:0] TAP_TOP = 6'h3f;

	// ----------------------------------------------------------------
	// Alignment search
	// ----------------------------------------------------------------
	localparam logic [3:0] ALIGN_RUN = 4'h8;
	localparam logic [5:0] ALIGN_BACK = 6'h04;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic staticTerm;
		logic dynTerm;
		logic fifoEn;
		logic autoAlign;
		logic halfRate;
		logic [3:0] width;
	} ctrl_s;

	localparam ctrl_s CTRL_RESET = '{
		staticTerm: 1'b0, dynTerm: 1'b1, fifoEn: 1'b0,
		autoAlign: 1'b0, halfRate: 1'b0, width: WIDTH_RESET};

	typedef struct packed {
		logic rxWordClk;
		logic rxBitClk;
		logic txWordClk;
		logic txBitClk;
		logic coreRdClk;
		logic txRst;
		logic bufOn;
		logic termOn;
		logic stepGo;
		logic stepUp;
		logic cntClr;
		logic qPop;
		logic driveOn;
		logic padIn;
	} pins_s;

	typedef enum logic [1:0] {
		AL_IDLE = 2'b00,
		AL_SCAN = 2'b01,
		AL_LOCK = 2'b10
	} align_e;

endpackage : lane_pkg

//--- sim/far_end_model.sv
// Far-end model: remote serial partner and lane clock source
`timescale 1ns/1ps
module far_end_model (
	input wire logic clk,
	input wire logic padPOut,
	output logic rxBitClk,
	output logic rxWordClk,
	output logic padIn,
	output logic txBitClk,
	output logic txWordClk
);
	// ----------------------------------------------------------------
	// Clock pacing
	// ----------------------------------------------------------------
	// Pins are oversampled by the lane, so a bit lasts nine clk cycles when received and eight when transmitted
	localparam int HALF = 4;
	// Half rate: one bit clock toggle per bit, both edges carry data
	logic halfRate = 1'b0;

	initial begin
		rxBitClk = 1'b0;
		rxWordClk = 1'b0;
		padIn = 1'b0;
		txBitClk = 1'b0;
		txWordClk = 1'b0;
	end

	// ----------------------------------------------------------------
	// Receive direction
	// ----------------------------------------------------------------
	// separate clocks, word per width bits
	task automatic send_word(input logic [9:0] w, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge clk) padIn <= w[i];
			repeat (HALF) @(posedge clk);
			// toggle per bit at half rate
			rxBitClk <= halfRate ? ~rxBitClk : 1'b1;
			repeat (HALF) @(posedge clk);
			if (!halfRate) begin
				rxBitClk <= 1'b0;
			end
			rxWordClk <= (i == n - 1);
		end
		repeat (HALF) @(posedge clk);
		// Idle line shows no stale bit; clocks stand still
		padIn <= ~padIn;
		rxWordClk <= 1'b0;
	endtask : send_word

	// ----------------------------------------------------------------
	// Transmit direction
	// ----------------------------------------------------------------
	// word edge then width bit edges
	task automatic take_word(input int n, output logic [9:0] w);
		w = '0;
		@(posedge clk) txWordClk <= 1'b1;
		repeat (HALF) @(posedge clk);
		txWordClk <= 1'b0;
		for (int i = 0; i < n; i++) begin
			// toggle per bit at half rate
			txBitClk <= halfRate ? ~txBitClk : 1'b1;
			repeat (HALF) @(posedge clk);
			if (!halfRate) begin
				txBitClk <= 1'b0;
			end
			repeat (HALF) @(posedge clk);
			w[i] = padPOut;
		end
	endtask : take_word
endmodule : far_end_model

//--- sim/lvds_bidir_serdes_lane_test.sv
// Self-checking bench for the bidirectional serdes lane
`timescale 1ns/1ps
module lvds_bidir_serdes_lane_test;
	localparam int LIMIT = 20000;
	// Tap kept at lock: last scanned tap stepped back to the run centre
	localparam int LOCK_TAP = int'(lane_pkg::ALIGN_RUN) - 1
		- int'(lane_pkg::ALIGN_BACK);
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic [7:0] regAddr = '0;
	logic [31:0] regWrData = '0;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic [31:0] regRdData;
	logic rx_word_clock, rx_bit_clock, tx_word_clock, tx_bit_clock, padIn;
	logic core_read_clock = 1'b0;
	logic rx_path_reset = 1'b0;
	logic tx_path_reset = 1'b0;
	logic input_buffer_on = 1'b1;
	logic line_resistor_on = 1'b0;
	logic delay_step_go = 1'b0;
	logic delay_step_up = 1'b0;
	logic delay_counter_clear = 1'b0;
	logic rx_queue_pop = 1'b0;
	logic pad_drive_on = 1'b1;
	logic [9:0] txWord = '0;
	logic [9:0] rxWord, got, mask;
	logic align_achieved, rx_queue_empty, padPOut, padNOut, padOeN;
	logic inputBufferEnable, termConnect;
	logic [5:0] align_tap_report, delayTap;
	int miscompares = 0;
	int checked = 0;
	int cycles = 0;
	int wids[3] = '{5, 1, 10};
	logic [9:0] rxPat[3] = '{10'h2e9, 10'h001, 10'h1c6};
	logic [9:0] txPat[3] = '{10'h3f3, 10'h3fe, 10'h2b5};

	always #5 clk = ~clk;

	lvds_bidir_serdes_lane dut (.clk(clk), .arst_n(arst_n),
		.regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
		.regRd(regRd), .regRdData(regRdData),
		.rx_word_clock(rx_word_clock), .rx_bit_clock(rx_bit_clock),
		.tx_word_clock(tx_word_clock), .tx_bit_clock(tx_bit_clock),
		.core_read_clock(core_read_clock), .rx_path_reset(rx_path_reset),
		.tx_path_reset(tx_path_reset), .input_buffer_on(input_buffer_on),
		.line_resistor_on(line_resistor_on), .delay_step_go(delay_step_go),
		.delay_step_up(delay_step_up),
		.delay_counter_clear(delay_counter_clear),
		.rx_queue_pop(rx_queue_pop), .pad_drive_on(pad_drive_on),
		.txWord(txWord), .padIn(padIn), .rxWord(rxWord),
		.align_achieved(align_achieved), .rx_queue_empty(rx_queue_empty),
		.align_tap_report(align_tap_report), .delayTap(delayTap),
		.padPOut(padPOut), .padNOut(padNOut), .padOeN(padOeN),
		.inputBufferEnable(inputBufferEnable), .termConnect(termConnect));

	far_end_model far (.clk(clk), .padPOut(padPOut),
		.rxBitClk(rx_bit_clock), .rxWordClk(rx_word_clock), .padIn(padIn),
		.txBitClk(tx_bit_clock), .txWordClk(tx_word_clock));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : complete_run

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
	endtask : reg_write

	task automatic read_check(input logic [7:0] a, input logic [31:0] exp,
		input string what);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		#1 check(what, regRdData, exp);
	endtask : read_check

	// Outputs come from oversampled pins, so allow the sync delay
	task automatic settle();
		repeat (3) @(posedge clk);
		#1;
	endtask : settle

	task automatic pop_pulse(input logic p);
		@(posedge clk) rx_queue_pop <= p;
		@(posedge clk) core_read_clock <= 1'b1;
		repeat (4) @(posedge clk);
		core_read_clock <= 1'b0;
		rx_queue_pop <= 1'b0;
		settle();
	endtask : pop_pulse

	always @(posedge clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			miscompares++;
			complete_run();
		end
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		#6 check("oe in reset", 32'(padOeN), 32'h1);
		check("n pad in reset", 32'(padNOut), 32'h1);
		check("empty in reset", 32'(rx_queue_empty), 32'h1);
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		read_check(lane_pkg::CTRL_ADDR, 32'h088, "ctrl reset");
		read_check(lane_pkg::PATTERN_ADDR, 32'h155, "pattern reset");
		read_check(lane_pkg::STATUS_ADDR, 32'h002, "status reset");
		read_check(8'h0c, 32'h0, "unmapped");
		reg_write(lane_pkg::CTRL_ADDR, 32'h080);
		read_check(lane_pkg::CTRL_ADDR, 32'h088, "width zero");
		reg_write(lane_pkg::CTRL_ADDR, 32'h08b);
		read_check(lane_pkg::CTRL_ADDR, 32'h088, "width eleven");
		// Both directions share one width; bits above it are dropped
		for (int k = 0; k < 3; k++) begin
			mask = lane_pkg::FULL_MASK >> (10 - wids[k]);
			reg_write(lane_pkg::CTRL_ADDR, 32'h080 | 32'(wids[k]));
			read_check(lane_pkg::CTRL_ADDR, 32'h080 | 32'(wids[k]), "w");
			far.send_word(rxPat[k], wids[k]);
			settle();
			check("rx word", 32'(rxWord), 32'(rxPat[k] & mask));
			@(posedge clk) txWord <= txPat[k];
			far.take_word(wids[k], got);
			check("tx word", 32'(got), 32'(txPat[k] & mask));
			check("n pad", 32'(padNOut), 32'(!padPOut));
			check("oe on", 32'(padOeN), 32'h0);
		end
		@(posedge clk) tx_path_reset <= 1'b1;
		settle();
		check("p pad tx reset", 32'(padPOut), 32'h0);
		check("rx kept", 32'(rxWord), 32'h1c6);
		@(posedge clk) tx_path_reset <= 1'b0;
		@(posedge clk) pad_drive_on <= 1'b0;
		settle();
		check("oe off", 32'(padOeN), 32'h1);
		@(posedge clk) pad_drive_on <= 1'b1;
		input_buffer_on <= 1'b0;
		far.send_word(10'h3ff, 10);
		settle();
		check("buffer off", 32'(inputBufferEnable), 32'h0);
		check("buffer off rx", 32'(rxWord), 32'h0);
		@(posedge clk) input_buffer_on <= 1'b1;
		line_resistor_on <= 1'b1;
		settle();
		check("buffer on", 32'(inputBufferEnable), 32'h1);
		check("term on", 32'(termConnect), 32'h1);
		@(posedge clk) line_resistor_on <= 1'b0;
		settle();
		check("term off", 32'(termConnect), 32'h0);
		reg_write(lane_pkg::CTRL_ADDR, 32'h10a);
		settle();
		check("static term", 32'(termConnect), 32'h1);
		reg_write(lane_pkg::CTRL_ADDR, 32'h08a);
		// Manual delay stepping, saturating at zero
		@(posedge clk) delay_step_go <= 1'b1;
		delay_step_up <= 1'b1;
		repeat (3) far.send_word(10'h0, 10);
		settle();
		check("tap up", 32'(delayTap), 32'h3);
		read_check(lane_pkg::STATUS_ADDR, 32'h00e, "status tap");
		@(posedge clk) delay_step_up <= 1'b0;
		repeat (4) far.send_word(10'h0, 10);
		settle();
		check("tap floor", 32'(delayTap), 32'h0);
		@(posedge clk) delay_step_up <= 1'b1;
		repeat (2) far.send_word(10'h0, 10);
		@(posedge clk) delay_step_go <= 1'b0;
		far.send_word(10'h0, 10);
		settle();
		check("tap held", 32'(delayTap), 32'h2);
		@(posedge clk) delay_counter_clear <= 1'b1;
		far.send_word(10'h0, 10);
		settle();
		check("tap clear", 32'(delayTap), 32'h0);
		@(posedge clk) delay_counter_clear <= 1'b0;
		// Receive FIFO
		reg_write(lane_pkg::CTRL_ADDR, 32'h0ca);
		far.send_word(10'h111, 10);
		far.send_word(10'h222, 10);
		settle();
		check("fifo filled", 32'(rx_queue_empty), 32'h0);
		pop_pulse(1'b0);
		read_check(lane_pkg::STATUS_ADDR, 32'h200, "no pop");
		pop_pulse(1'b1);
		check("pop one", 32'(rxWord), 32'h111);
		pop_pulse(1'b1);
		check("pop two", 32'(rxWord), 32'h222);
		check("fifo empty", 32'(rx_queue_empty), 32'h1);
		pop_pulse(1'b1);
		check("pop empty", 32'(rxWord), 32'h222);
		far.send_word(10'h333, 10);
		settle();
		check("fifo one", 32'(rx_queue_empty), 32'h0);
		@(posedge clk) rx_path_reset <= 1'b1;
		#1 check("rx reset empty", 32'(rx_queue_empty), 32'h1);
		check("rx reset word", 32'(rxWord), 32'h0);
		// Held across two edges so no check sees a half-applied clear
		repeat (2) @(posedge clk);
		rx_path_reset <= 1'b0;
		// Automatic alignment on a fixed training pattern
		reg_write(lane_pkg::CTRL_ADDR, 32'h0a8);
		reg_write(lane_pkg::PATTERN_ADDR, 32'h0a5);
		@(posedge clk) delay_step_go <= 1'b1;
		repeat (7) far.send_word(10'h0a5, 8);
		settle();
		check("no early lock", 32'(align_achieved), 32'h0);
		repeat (3) far.send_word(10'h0a5, 8);
		settle();
		check("lock", 32'(align_achieved), 32'h1);
		check("tap report", 32'(align_tap_report), 32'(LOCK_TAP));
		check("tap chosen", 32'(delayTap), 32'(LOCK_TAP));
		@(posedge clk) delay_counter_clear <= 1'b1;
		far.send_word(10'h0a5, 8);
		settle();
		check("align clear", 32'(align_achieved), 32'h0);
		@(posedge clk) delay_counter_clear <= 1'b0;
		// Half rate: manual stepping even with automatic alignment set
		reg_write(lane_pkg::CTRL_ADDR, 32'h0ba);
		@(posedge clk) far.halfRate <= 1'b1;
		far.send_word(10'h2c9, 10);
		settle();
		check("half rx word", 32'(rxWord), 32'h2c9);
		check("half tap step", 32'(delayTap), 32'h1);
		check("half no lock", 32'(align_achieved), 32'h0);
		@(posedge clk) txWord <= 10'h1b4;
		far.take_word(10, got);
		check("half tx word", 32'(got), 32'h1b4);
		complete_run();
	end
endmodule : lvds_bidir_serdes_lane_test
